// [core/ir_pulse_decoder.sv]
`timescale 1ns/10ps
`include "uart_ctl_defines.svh"

module ir_pulse_decoder (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic pulse_n,
	input wire logic enable,
	input wire logic baud_tick,
	output logic bit_q
);
	logic prev_q;
	logic [4:0] cnt_q;

	// A falling edge marks a zero bit held for one bit period
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 1'b1;
			cnt_q <= 5'h00;
			bit_q <= 1'b1;
		end else begin
			prev_q <= pulse_n;
			if (!enable) begin
				cnt_q <= 5'h00; // see [RULE_12]
				bit_q <= 1'b1;
			end else if (prev_q && !pulse_n) begin
				cnt_q <= 5'h00;
				bit_q <= 1'b0;
			end else if (!bit_q && baud_tick) begin
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == `TICKS_PER_BIT - 5'h01)
					bit_q <= 1'b1;
			end
		end
	end
endmodule

// [core/ir_pulse_encoder.sv]
`timescale 1ns/10ps
`include "uart_ctl_defines.svh"

module ir_pulse_encoder import uart_ctl_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic bit_in,
	input wire logic enable,
	input wire logic low_power,
	input wire logic baud_tick,
	input wire logic lp_tick,
	output logic pulse_q
);
	enc_state_t state_q;
	logic [3:0] phase_q;
	logic [3:0] cnt_q;
	logic prev_bit_q;
	logic pulse_tick;

	// Pulse length counted on the x16 tick or on the low-power tick
	assign pulse_tick = low_power ? lp_tick : baud_tick;

	// Bit phase, realigned on every edge of the serial stream
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= 4'h0;
			prev_bit_q <= 1'b1;
		end else begin
			prev_bit_q <= bit_in;
			if (bit_in != prev_bit_q)
				phase_q <= 4'h0;
			else if (baud_tick)
				phase_q <= phase_q + 4'h1;
		end
	end

	// Zero bits start one pulse at phase 0
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ENC_IDLE;
			cnt_q <= 4'h0;
			pulse_q <= 1'b0;
		end else if (!enable) begin
			state_q <= ENC_IDLE; // see [RULE_12]
			pulse_q <= 1'b0;
		end else begin
			case (state_q)
				ENC_IDLE: begin
					if (baud_tick && phase_q == 4'h0 && !bit_in) begin
						state_q <= ENC_PULSE; // see [RULE_08]
						cnt_q <= 4'h0;
						pulse_q <= 1'b1;
					end
				end
				ENC_PULSE: begin
					if (pulse_tick) begin
						cnt_q <= cnt_q + 4'h1; // see [RULE_09]
						if (cnt_q == `IR_PULSE_TICKS - 4'h1) begin
							state_q <= ENC_IDLE;
							pulse_q <= 1'b0;
						end
					end
				end
				default: state_q <= ENC_IDLE;
			endcase
		end
	end

	AST_IR_OFF_LOW: assert property (@(posedge clock) disable iff (!reset_n)
		!enable |=> !pulse_q) else $error("ir pulse while codec off"); // see [RULE_12]
endmodule

// [core/uart_ctl_defines.svh]
`ifndef UART_CTL_DEFINES_SVH
`define UART_CTL_DEFINES_SVH

// Register offsets (byte addresses)
`define OFS_BAUD_DIV 8'h10
`define OFS_PORT_CONTROL 8'h14
`define OFS_LINE_FLAG_STATUS 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_LP_DIV 8'h20
`define OFS_TEST_MODE 8'h24

// Field positions in port_control
`define BIT_LOOPBACK_ENABLE 7
`define BIT_RX_TIMEOUT_IRQ_ENABLE 6
`define BIT_TX_IRQ_ENABLE 5
`define BIT_RX_IRQ_ENABLE 4
`define BIT_MODEM_IRQ_ENABLE 3
`define BIT_IR_LOW_POWER_MODE 2
`define BIT_IR_CODEC_ENABLE 1
`define BIT_PORT_ENABLE 0

// Field positions in test_mode_register
`define BIT_IR_TEST_OVERRIDE 1

// Reset values
`define RST_PORT_CONTROL 8'h00
`define RST_LINE_FLAG_STATUS 8'h90
`define RST_TEST_MODE 8'h00
`define RST_DIV 8'h00

// Timing: IR pulse length in x16 ticks, x16 ticks per bit
`define IR_PULSE_TICKS 4'h3
`define TICKS_PER_BIT 5'h10

`endif

// [core/uart_ctl_pkg.sv]
package uart_ctl_pkg;

	// Flags that the serial core reports
	typedef struct packed {
		logic tx_fifo_empty;
		logic rx_fifo_full;
		logic tx_fifo_full;
		logic rx_fifo_empty;
		logic busy;
	} core_flags_t;

	// Interrupt sources, bit order as in the status register
	typedef struct packed {
		logic rx_timeout;
		logic tx;
		logic rx;
		logic modem;
	} irq_vec_t;

	typedef enum logic {ENC_IDLE, ENC_PULSE} enc_state_t;

endpackage

// [core/uart_ctl_top.sv]
// Operation
// [RULE_01] Loopback with IR and test bit: inverted feedback
// [RULE_02] Software sets, later clears, IR test bit
// [RULE_03] Loopback enable clears at reset
// [RULE_04] Bit 6 enables receive timeout interrupt
// [RULE_05] Bit 5 enables transmit interrupt
// [RULE_06] Bit 4 enables receive interrupt
// [RULE_07] Bit 3 enables modem status interrupt
// [RULE_08] Normal IR zero: pulse of 3/16 bit
// [RULE_09] Low power IR zero: three low-power ticks
// [RULE_10] IR enable needs port enable too
// [RULE_11] IR active: serial TX high, RX ignored
// [RULE_12] IR inactive: IR output low, input ignored
// [RULE_13] Bit 0 enables port, pins by IR bit
// [RULE_14] Flags reset: full/busy 0, empty 1
// [RULE_15] Combined interrupt output besides four
// [RULE_16] Each irq is source AND enable; OR combined
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "uart_ctl_defines.svh"

module uart_ctl_top import uart_ctl_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic core_txd,
	output logic core_rxd,
	input wire core_flags_t core_flags,
	input wire irq_vec_t core_events,
	input wire logic [2:0] modem_n_in,
	input wire logic serial_rx_line,
	output logic serial_tx_line,
	input wire logic ir_rx_in,
	output logic ir_tx_out_n,
	output logic baud_x16_tick,
	output logic low_power_x16_tick,
	output irq_vec_t irq_out,
	output logic combined_irq
);
	logic [7:0] port_control_q;
	logic [7:0] test_mode_q;
	logic [7:0] baud_div_q;
	logic [7:0] lp_div_q;
	logic [7:0] baud_cnt_q;
	logic [7:0] lp_cnt_q;
	logic [7:0] line_flag_q;
	irq_vec_t irq_status_q;
	irq_vec_t irq_set;
	irq_vec_t irq_enable;
	logic [2:0] modem_meta_q;
	logic [2:0] modem_sync_q;
	logic [2:0] modem_prev_q;
	logic [1:0] rx_line_sync_q;
	logic [1:0] ir_rx_sync_q;
	logic port_enable;
	logic ir_codec_enable;
	logic ir_active;
	logic serial_active;
	logic loopback_active;
	logic ir_pulse;
	logic ir_decoded;
	logic ir_rx_source;
	logic wr_hit_ctl;
	logic [7:0] rdata_d;

	// Decoded control fields
	assign port_enable = port_control_q[`BIT_PORT_ENABLE];
	assign ir_codec_enable = port_control_q[`BIT_IR_CODEC_ENABLE];
	assign ir_active = port_enable && ir_codec_enable; // see [RULE_10]
	assign serial_active = port_enable && !ir_codec_enable; // see [RULE_13]
	// Software must drop the test bit after the loop test; see [RULE_02]
	assign loopback_active = ir_active
		&& port_control_q[`BIT_LOOPBACK_ENABLE]
		&& test_mode_q[`BIT_IR_TEST_OVERRIDE]; // see [RULE_01]
	assign irq_enable = '{
		rx_timeout: port_control_q[`BIT_RX_TIMEOUT_IRQ_ENABLE],
		tx: port_control_q[`BIT_TX_IRQ_ENABLE],
		rx: port_control_q[`BIT_RX_IRQ_ENABLE],
		modem: port_control_q[`BIT_MODEM_IRQ_ENABLE]
	};
	assign wr_hit_ctl = reg_write && reg_addr == `OFS_PORT_CONTROL;

	// Divider step: zero divisor stops the tick entirely
	function automatic logic [7:0] div_next(input logic [7:0] cnt,
		input logic [7:0] div);
		div_next = (div == 8'h00 || cnt == 8'h00) ? div : cnt - 8'h01;
	endfunction

	function automatic logic div_tick(input logic [7:0] cnt,
		input logic [7:0] div);
		div_tick = div != 8'h00 && cnt == 8'h00;
	endfunction

	// Pin synchronisers; first stage read by second only
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			modem_meta_q <= 3'h7;
			modem_sync_q <= 3'h7;
			rx_line_sync_q <= 2'h3;
			ir_rx_sync_q <= 2'h3;
		end else begin
			modem_meta_q <= modem_n_in;
			modem_sync_q <= modem_meta_q;
			rx_line_sync_q <= {rx_line_sync_q[0], serial_rx_line};
			ir_rx_sync_q <= {ir_rx_sync_q[0], ir_rx_in};
		end
	end

	// Control registers written by software
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_control_q <= `RST_PORT_CONTROL; // see [RULE_03]
			test_mode_q <= `RST_TEST_MODE;
			baud_div_q <= `RST_DIV;
			lp_div_q <= `RST_DIV;
		end else if (reg_write) begin
			case (reg_addr)
				`OFS_PORT_CONTROL: port_control_q <= reg_wdata;
				`OFS_TEST_MODE: test_mode_q <= reg_wdata &
					(8'h01 << `BIT_IR_TEST_OVERRIDE);
				`OFS_BAUD_DIV: baud_div_q <= reg_wdata;
				`OFS_LP_DIV: lp_div_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Bit-rate and low-power tick dividers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			baud_cnt_q <= 8'h00;
			lp_cnt_q <= 8'h00;
			baud_x16_tick <= 1'b0;
			low_power_x16_tick <= 1'b0;
		end else begin
			baud_cnt_q <= div_next(baud_cnt_q, baud_div_q);
			lp_cnt_q <= div_next(lp_cnt_q, lp_div_q);
			baud_x16_tick <= div_tick(baud_cnt_q, baud_div_q);
			low_power_x16_tick <= div_tick(lp_cnt_q, lp_div_q);
		end
	end

	// IR encoder on the transmit stream
	ir_pulse_encoder u_enc (
		.clock(clock),
		.reset_n(reset_n),
		.bit_in(core_txd),
		.enable(ir_active),
		.low_power(port_control_q[`BIT_IR_LOW_POWER_MODE]),
		.baud_tick(baud_x16_tick),
		.lp_tick(low_power_x16_tick),
		.pulse_q(ir_pulse)
	);

	// Loop path feeds the inverted pulse back to the decoder
	assign ir_rx_source = loopback_active ? !ir_pulse
		: ir_rx_sync_q[1]; // see [RULE_01]

	ir_pulse_decoder u_dec (
		.clock(clock),
		.reset_n(reset_n),
		.pulse_n(ir_rx_source),
		.enable(ir_active), // see [RULE_12]
		.baud_tick(baud_x16_tick),
		.bit_q(ir_decoded)
	);

	// Line muxing; idle lines sit at the marking level
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			serial_tx_line <= 1'b1;
			ir_tx_out_n <= 1'b0;
			core_rxd <= 1'b1;
		end else begin
			serial_tx_line <= serial_active ? core_txd : 1'b1; // see [RULE_11]
			ir_tx_out_n <= ir_active && ir_pulse; // see [RULE_12]
			if (ir_active)
				core_rxd <= ir_decoded; // see [RULE_11]
			else if (serial_active)
				core_rxd <= rx_line_sync_q[1]; // see [RULE_13]
			else
				core_rxd <= 1'b1;
		end
	end

	// Flag register snapshot; empties read 1 after reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			line_flag_q <= `RST_LINE_FLAG_STATUS; // see [RULE_14]
		end else begin
			line_flag_q <= {core_flags.tx_fifo_empty,
				core_flags.rx_fifo_full, core_flags.tx_fifo_full,
				core_flags.rx_fifo_empty, core_flags.busy,
				~modem_sync_q};
		end
	end

	// Modem changes count whenever IR mode is not active, port enabled or not
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			modem_prev_q <= 3'h7;
		else
			modem_prev_q <= modem_sync_q;
	end

	always_comb begin
		irq_set = core_events;
		irq_set.modem = core_events.modem ||
			(!ir_active && modem_sync_q != modem_prev_q); // see [RULE_11]
	end

	// Sticky sources, write one to clear; a new event wins
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_status_q <= '0;
		end else if (reg_write && reg_addr == `OFS_IRQ_STATUS) begin
			irq_status_q <= (irq_status_q & ~irq_vec_t'(reg_wdata[3:0]))
				| irq_set;
		end else begin
			irq_status_q <= irq_status_q | irq_set;
		end
	end

	// Interrupt outputs: source AND enable, then OR of all four
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_out <= '0;
			combined_irq <= 1'b0;
		end else begin
			irq_out.rx_timeout <= irq_status_q.rx_timeout
				&& irq_enable.rx_timeout; // see [RULE_04]
			irq_out.tx <= irq_status_q.tx && irq_enable.tx; // see [RULE_05]
			irq_out.rx <= irq_status_q.rx && irq_enable.rx; // see [RULE_06]
			irq_out.modem <= irq_status_q.modem
				&& irq_enable.modem; // see [RULE_07]
			combined_irq <= |(irq_status_q & irq_enable); // see [RULE_15]
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb begin
		case (reg_addr)
			`OFS_PORT_CONTROL: rdata_d = port_control_q;
			`OFS_LINE_FLAG_STATUS: rdata_d = line_flag_q;
			`OFS_IRQ_STATUS: rdata_d = {4'h0, irq_status_q};
			`OFS_BAUD_DIV: rdata_d = baud_div_q;
			`OFS_LP_DIV: rdata_d = lp_div_q;
			`OFS_TEST_MODE: rdata_d = test_mode_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_read ? rdata_d : 8'h00;
	end

	// Checks
	sequence seq_ctl_write_zero;
		wr_hit_ctl && reg_wdata == 8'h00;
	endsequence

	sequence seq_ir_zero_start;
		ir_active && !port_control_q[`BIT_IR_LOW_POWER_MODE]
			&& !ir_pulse && baud_x16_tick && !core_txd
			&& core_txd == $past(core_txd) && u_enc.phase_q == 4'h0
			&& u_enc.state_q == ENC_IDLE;
	endsequence

	AST_RST_FLAGS: assert property (@(posedge clock) // see [RULE_14]
		$rose(reset_n) |-> line_flag_q[7:3] == 5'b10010)
		else $error("flag reset value wrong");

	AST_LOOPBACK_OFF: assert property (@(posedge clock) // see [RULE_03]
		disable iff (!reset_n) seq_ctl_write_zero |=> !loopback_active)
		else $error("loopback stays on after clear");

	AST_LOOP_PATH: assert property (@(posedge clock) // see [RULE_01]
		disable iff (!reset_n)
		loopback_active |-> ir_rx_source == !ir_pulse)
		else $error("loop path not inverted pulse");

	AST_IR_NEEDS_PORT: assert property (@(posedge clock) // see [RULE_10]
		disable iff (!reset_n)
		!port_enable ##1 !port_enable |-> !ir_tx_out_n && serial_tx_line)
		else $error("IR active without port enable");

	AST_SERIAL_MARK: assert property (@(posedge clock) // see [RULE_11]
		disable iff (!reset_n) ir_active |=> serial_tx_line)
		else $error("serial tx not marking in IR mode");

	AST_IR_QUIET: assert property (@(posedge clock) // see [RULE_12]
		disable iff (!reset_n) !ir_active |=> !ir_tx_out_n)
		else $error("IR output high while IR off");

	AST_PULSE_START: assert property (@(posedge clock) // see [RULE_08]
		disable iff (!reset_n) seq_ir_zero_start |=> ir_pulse)
		else $error("zero bit gave no pulse");

	AST_TX_MASK: assert property (@(posedge clock) // see [RULE_05]
		disable iff (!reset_n)
		irq_out.tx |-> $past(irq_status_q.tx && irq_enable.tx))
		else $error("tx irq not source and enable");

	AST_RT_MASK: assert property (@(posedge clock) // see [RULE_04]
		disable iff (!reset_n) !irq_enable.rx_timeout ##1
		!irq_enable.rx_timeout |-> !irq_out.rx_timeout)
		else $error("rx timeout irq leaked while masked");

	AST_RX_MASK: assert property (@(posedge clock) // see [RULE_06]
		disable iff (!reset_n)
		irq_status_q.rx && irq_enable.rx |=> irq_out.rx)
		else $error("rx irq missing");

	AST_MS_MASK: assert property (@(posedge clock) // see [RULE_07]
		disable iff (!reset_n)
		irq_out.modem |-> $past(irq_enable.modem))
		else $error("modem irq while masked");

	AST_COMBINED: assert property (@(posedge clock) // see [RULE_16]
		disable iff (!reset_n) combined_irq == |irq_out)
		else $error("combined irq not OR of four");

	AST_STICKY_SET: assert property (@(posedge clock) // see [RULE_15]
		disable iff (!reset_n) |irq_set |=> |irq_status_q ##1 combined_irq
		|| !(|(irq_status_q & irq_enable)))
		else $error("event lost before combined irq");
endmodule

// [tb/ir_line_model.sv]
`timescale 1ns/10ps

module ir_line_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic ir_tx_out_n,
	output logic ir_rx_in,
	output int pulse_w
);
	int run_q;

	// Width of the last light pulse, judged by the bench afterwards
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 0;
			pulse_w <= 0;
		end else if (ir_tx_out_n) begin
			run_q <= run_q + 1;
		end else begin
			if (run_q != 0) pulse_w <= run_q;
			run_q <= 0;
		end
	end

	// Receiver output idles high; light shows as a low pulse
	initial ir_rx_in = 1'b1;

	task automatic flash(input int n);
		@(posedge clock);
		ir_rx_in <= 1'b0;
		repeat (n) @(posedge clock);
		ir_rx_in <= 1'b1;
	endtask
endmodule

// [tb/uart_ctl_top_tb.sv]
`timescale 1ns/10ps
`include "uart_ctl_defines.svh"

module uart_ctl_top_tb import uart_ctl_pkg::*; ;
	logic clock, reset_n, reg_write, reg_read, core_txd, core_rxd;
	logic serial_rx_line, serial_tx_line, ir_rx_in, ir_tx_out_n;
	logic baud_x16_tick, low_power_x16_tick, combined_irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] modem_n_in;
	core_flags_t core_flags;
	irq_vec_t core_events, irq_out;
	int error_cnt, checks_done, pulse_w;

	uart_ctl_top DUT (
		.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .core_txd(core_txd), .core_rxd(core_rxd),
		.core_flags(core_flags), .core_events(core_events),
		.modem_n_in(modem_n_in), .serial_rx_line(serial_rx_line),
		.serial_tx_line(serial_tx_line), .ir_rx_in(ir_rx_in),
		.ir_tx_out_n(ir_tx_out_n), .baud_x16_tick(baud_x16_tick),
		.low_power_x16_tick(low_power_x16_tick), .irq_out(irq_out),
		.combined_irq(combined_irq)
	);

	ir_line_model lm (
		.clock(clock), .reset_n(reset_n), .ir_tx_out_n(ir_tx_out_n),
		.ir_rx_in(ir_rx_in), .pulse_w(pulse_w)
	);

	// Free-running 25 MHz clock
	always #20 clock = ~clock;

	task automatic results;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle strobes, launched right after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask

	// Bounded wait on the received stream; a hang ends the run
	task automatic wait_rxd(input string what, input logic val, input int lim);
		int n;
		n = 0;
		while (core_rxd !== val) begin
			if (n == lim) begin
				error_cnt++;
				$display("ERROR %s expected %b seen %b", what, val, core_rxd);
				results();
			end
			@(posedge clock);
			#1 n++;
		end
		checks_done++;
	endtask

	task automatic t_regs;
		rd("control reset", `OFS_PORT_CONTROL, 8'h00);
		rd("flags reset", `OFS_LINE_FLAG_STATUS, 8'h90);
		wr(`OFS_LINE_FLAG_STATUS, 8'h00);
		rd("flags read only", `OFS_LINE_FLAG_STATUS, 8'h90);
		wr(`OFS_PORT_CONTROL, 8'ha5);
		rd("control rw", `OFS_PORT_CONTROL, 8'ha5);
		wr(`OFS_PORT_CONTROL, 8'h00);
		wr(`OFS_TEST_MODE, 8'hff);
		rd("test mode", `OFS_TEST_MODE, 8'h02);
		wr(`OFS_TEST_MODE, 8'h00);
		rd("unmapped", 8'h30, 8'h00);
	endtask

	// Each source: masked, then unmasked, then cleared
	task automatic t_irq;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			core_events <= irq_vec_t'(4'h1 << i);
			@(posedge clock);
			core_events <= '0;
			repeat (3) @(posedge clock);
			#1 chk("irq masked", 8'h00, {3'h0, combined_irq, irq_out});
			wr(`OFS_PORT_CONTROL, 8'h08 << i);
			repeat (2) @(posedge clock);
			#1 chk("irq on", {4'h1, 4'h1 << i}, {3'h0, combined_irq, irq_out});
			wr(`OFS_IRQ_STATUS, 8'h01 << i);
			repeat (2) @(posedge clock);
			#1 chk("irq clear", 8'h00, {3'h0, combined_irq, irq_out});
		end
	endtask

	// Plain pins in use; IR stays dark and deaf
	task automatic t_serial;
		wr(`OFS_PORT_CONTROL, 8'h01);
		@(posedge clock);
		core_txd <= 1'b0;
		serial_rx_line <= 1'b0;
		repeat (40) @(posedge clock);
		#1 chk("serial lines", 8'h00, {6'h0, serial_tx_line, core_rxd});
		@(posedge clock);
		core_txd <= 1'b1;
		serial_rx_line <= 1'b1;
		lm.flash(3);
		repeat (8) @(posedge clock);
		#1 chk("ir ignored", 8'h01, {7'h0, core_rxd});
		wr(`OFS_PORT_CONTROL, 8'h02);
		@(posedge clock);
		core_txd <= 1'b0;
		repeat (40) @(posedge clock);
		core_txd <= 1'b1;
		#1 chk("no light", 8'h00, pulse_w[7:0]);
	endtask

	// One zero bit in IR mode; lp pulse start is not tick aligned
	task automatic t_ir_tx(input logic [7:0] ctl, input int lo, input int hi);
		wr(`OFS_PORT_CONTROL, ctl);
		@(posedge clock);
		core_txd <= 1'b0;
		serial_rx_line <= 1'b0;
		repeat (32) @(posedge clock);
		#1 chk("ir mode lines", 8'h03, {6'h0, serial_tx_line, core_rxd});
		@(posedge clock);
		core_txd <= 1'b1;
		serial_rx_line <= 1'b1;
		repeat (16) @(posedge clock);
		checks_done++;
		if (pulse_w < lo || pulse_w > hi) begin
			error_cnt++;
			$display("ERROR ir pulse expected %0d..%0d seen %0d", lo, hi, pulse_w);
		end
	endtask

	task automatic t_loop(input logic [7:0] tm, input logic exp);
		wr(`OFS_TEST_MODE, tm);
		wr(`OFS_PORT_CONTROL, 8'h83);
		@(posedge clock);
		core_txd <= 1'b0;
		repeat (20) @(posedge clock);
		#1 chk("loopback", {7'h0, exp}, {7'h0, core_rxd});
		@(posedge clock);
		core_txd <= 1'b1;
		repeat (60) @(posedge clock);
		wr(`OFS_TEST_MODE, 8'h00);
	endtask

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		core_txd = 1'b1;
		serial_rx_line = 1'b1;
		modem_n_in = 3'h7;
		core_events = '0;
		core_flags = core_flags_t'(5'h12);
		error_cnt = 0;
		checks_done = 0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		t_regs();
		t_irq();
		wr(`OFS_BAUD_DIV, 8'h01);
		wr(`OFS_LP_DIV, 8'h07);
		t_serial();
		t_ir_tx(8'h03, 6, 6);
		t_ir_tx(8'h07, 17, 24);
		wr(`OFS_PORT_CONTROL, 8'h03);
		lm.flash(3);
		wait_rxd("ir rx start", 1'b0, 12);
		wait_rxd("ir rx end", 1'b1, 60);
		t_loop(8'h00, 1'b1);
		t_loop(8'h02, 1'b0);
		results();
	end
endmodule
